// File: hdl/ecc_path_consts.svh
// Sizes and counts shared by the on-die error-correction path
`ifndef ECC_PATH_CONSTS_SVH
`define ECC_PATH_CONSTS_SVH

`define ECC_DATA_W 64
`define ECC_CHK_W 8
`define ECC_WORD_W 72
`define ECC_SYN_W 7
`define ECC_BEAT_W 16
`define ECC_LANE_W 8
`define ECC_LANES 2
`define ECC_CNT_W 2
`define ECC_ADDR_W 4
`define ECC_DEPTH 16
`define ECC_FIFO_DEPTH 4
`define ECC_FIFO_LVL_W 3
`define ECC_FIFO_W 66
`define ECC_RESET_WORD 72'h0

`endif

// File: hdl/ecc_path_pkg.sv
// Types of the on-die error-correction path
`include "ecc_path_consts.svh"

package ecc_path_pkg;

  typedef enum logic {
    WR_IDLE,
    WR_BEATS
  } wr_state_t;

  typedef struct packed {
    logic [`ECC_DEPTH-1:0][`ECC_WORD_W-1:0] mem;
    wr_state_t st;
    logic [`ECC_ADDR_W-1:0] waddr;
    logic [`ECC_CNT_W-1:0] wleft;
    logic [`ECC_CNT_W-1:0] wbeat;
    logic [`ECC_DATA_W-1:0] asm_word;
    logic limited;
    logic wr_limited;
    logic cmd_ready;
    logic [`ECC_DATA_W-1:0] rword;
    logic [`ECC_CNT_W-1:0] rbeat;
    logic [`ECC_CNT_W-1:0] rleft;
    logic dq_oe;
    logic [`ECC_BEAT_W-1:0] dq_out;
  } path_state_t;

endpackage

// File: hdl/word_fifo.sv
// Small flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none

module word_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4,
  parameter int AW = 2
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [AW:0] level
);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } fifo_state_t;

  fifo_state_t s;
  fifo_state_t next_s;
  logic push;
  logic pop;

  assign in_ready = (s.cnt != (AW+1)'(DEPTH));
  assign out_valid = (s.cnt != '0);
  assign out_data = s.mem[s.rp];
  assign level = s.cnt;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb
  begin
    next_s = s;
    if (push)
    begin
      next_s.mem[s.wp] = in_data;
      next_s.wp = s.wp + 1'b1;
    end
    if (pop)
    begin
      next_s.rp = s.rp + 1'b1;
    end
    next_s.cnt = (AW+1)'(s.cnt + (AW+1)'(push) - (AW+1)'(pop));
  end

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

endmodule // word_fifo

`default_nettype wire

// File: hdl/sdram_on_die_ecc_path.sv
// Error-correction path of the DRAM: write assembly, check bits, read correction
//
// What this block does
// - Eight check bits stored per written word
// - Read fetches whole 72-bit word, Hamming decodes
// - Exactly one wrong bit gets corrected
// - Corrected word leaves in 16-bit beats
// - Encoding and correction add no cycles
// - Reads never rewrite the stored array
// - Short writes flagged as limited protection
// - Correction always on, no switch
// - Everything sampled on rising clock edge
`timescale 1ns/1ps
`default_nettype none

module sdram_on_die_ecc_path
  import ecc_path_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [`ECC_ADDR_W-1:0] cmd_addr,
  input wire logic [`ECC_CNT_W-1:0] cmd_beats,
  output logic cmd_ready,
  input wire logic dq_in_valid,
  input wire logic [`ECC_BEAT_W-1:0] dq_in,
  input wire logic [`ECC_LANES-1:0] dq_mask,
  output logic [`ECC_BEAT_W-1:0] dq_out,
  output logic dq_oe,
  input wire logic dq_ready,
  output logic wr_limited,
  input wire logic flip_en,
  input wire logic [`ECC_ADDR_W-1:0] flip_addr,
  input wire logic [`ECC_SYN_W-1:0] flip_bit
);

  import ecc_path_pkg::*;

  // Check bits 0..6 are Hamming parities over positions 1..71, bit 7 is overall parity
  function automatic logic [`ECC_CHK_W-1:0] ecc_gen(input logic [`ECC_DATA_W-1:0] d);
    logic [`ECC_CHK_W-1:0] c;
    int k;
    c = '0;
    k = 0;
    for (int p = 1; p < `ECC_WORD_W; p++)
    begin
      if ((p & (p - 1)) != 0)
      begin
        if (d[k])
        begin
          c[`ECC_SYN_W-1:0] = c[`ECC_SYN_W-1:0] ^ `ECC_SYN_W'(p);
        end
        k++;
      end
    end
    c[`ECC_CHK_W-1] = ^{d, c[`ECC_SYN_W-1:0]};
    return c;
  endfunction

  // single-bit correction
  // Flips one data bit when the syndrome names it and overall parity is odd.
  // An even parity with a nonzero syndrome is a multi-bit hit: data goes out raw.
  function automatic logic [`ECC_DATA_W-1:0] ecc_fix(input logic [`ECC_WORD_W-1:0] w);
    logic [`ECC_SYN_W-1:0] syn;
    logic par;
    logic [`ECC_DATA_W-1:0] d;
    int k;
    syn = w[`ECC_DATA_W +: `ECC_SYN_W];
    par = ^w;
    d = w[`ECC_DATA_W-1:0];
    k = 0;
    for (int p = 1; p < `ECC_WORD_W; p++)
    begin
      if ((p & (p - 1)) != 0)
      begin
        if (w[k])
        begin
          syn = syn ^ `ECC_SYN_W'(p);
        end
        k++;
      end
    end
    k = 0;
    for (int p = 1; p < `ECC_WORD_W; p++)
    begin
      if ((p & (p - 1)) != 0)
      begin
        if (par && (syn == `ECC_SYN_W'(p)))
        begin
          d[k] = ~d[k];
        end
        k++;
      end
    end
    return d;
  endfunction

  path_state_t s;
  path_state_t next_s;
  logic rd_go;
  logic wr_go;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [`ECC_FIFO_W-1:0] fifo_in_data;
  logic [`ECC_FIFO_W-1:0] fifo_out_data;
  logic [`ECC_FIFO_LVL_W-1:0] fifo_level;
  logic [`ECC_FIFO_LVL_W-1:0] lvl_next;
  logic [`ECC_WORD_W-1:0] rd_raw;

  assign rd_go = cmd_valid && s.cmd_ready && !cmd_write;
  assign wr_go = cmd_valid && s.cmd_ready && cmd_write;
  assign rd_raw = s.mem[cmd_addr];
  // no path around decoder
  // Decoding sits in the fetch cycle, so the buffer sees corrected data at once
  assign fifo_in_data = {cmd_beats, ecc_fix(rd_raw)};
  assign fifo_out_ready = !s.dq_oe || (dq_ready && (s.rleft == '0));

  word_fifo #(
    .WIDTH(`ECC_FIFO_W),
    .DEPTH(`ECC_FIFO_DEPTH),
    .AW(`ECC_CNT_W)
  ) u_rd_fifo (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .in_valid(rd_go),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data),
    .level(fifo_level)
  );

  always_comb
  begin
    next_s = s;
    next_s.wr_limited = 1'b0;
    lvl_next = `ECC_FIFO_LVL_W'(fifo_level + `ECC_FIFO_LVL_W'(rd_go)
      - `ECC_FIFO_LVL_W'(fifo_out_valid && fifo_out_ready));
    case (s.st)
      WR_IDLE:
      begin
        if (wr_go)
        begin
          next_s.st = WR_BEATS;
          next_s.waddr = cmd_addr;
          next_s.wleft = cmd_beats;
          next_s.wbeat = '0;
          // merge base is stored data
          // Unwritten lanes keep the corrected old data, so a single latent bad bit is not carried over; a multi-bit hit is kept raw
          next_s.asm_word = ecc_fix(rd_raw);
          next_s.limited = (cmd_beats != 2'h3);
        end
      end
      WR_BEATS:
      begin
        if (dq_in_valid)
        begin
          for (int b = 0; b < `ECC_LANES; b++)
          begin
            if (!dq_mask[b])
            begin
              next_s.asm_word[{s.wbeat, 1'(b), 3'h0} +: `ECC_LANE_W] =
                dq_in[b*`ECC_LANE_W +: `ECC_LANE_W];
            end
          end
          if (s.wleft == '0)
          begin
            next_s.mem[s.waddr] = {ecc_gen(next_s.asm_word), next_s.asm_word};
            next_s.wr_limited = s.limited;
            next_s.st = WR_IDLE;
          end
          else
          begin
            next_s.wleft = s.wleft - 1'b1;
            next_s.wbeat = s.wbeat + 1'b1;
          end
        end
      end
      default:
      begin
        next_s.st = WR_IDLE;
      end
    endcase
    // Test hook: upsets one stored bit to stand in for a weak cell
    if (flip_en && (flip_bit < `ECC_SYN_W'(`ECC_WORD_W)))
    begin
      next_s.mem[flip_addr][flip_bit] = ~next_s.mem[flip_addr][flip_bit];
    end
    if (s.dq_oe && dq_ready && (s.rleft != '0))
    begin
      next_s.rbeat = s.rbeat + 1'b1;
      next_s.rleft = s.rleft - 1'b1;
      next_s.dq_out = s.rword[{next_s.rbeat, 4'h0} +: `ECC_BEAT_W];
    end
    else if (fifo_out_valid && fifo_out_ready)
    begin
      next_s.rword = fifo_out_data[`ECC_DATA_W-1:0];
      next_s.rleft = fifo_out_data[`ECC_DATA_W +: `ECC_CNT_W];
      next_s.rbeat = '0;
      next_s.dq_out = fifo_out_data[`ECC_BEAT_W-1:0];
      next_s.dq_oe = 1'b1;
    end
    else if (fifo_out_ready)
    begin
      next_s.dq_oe = 1'b0;
      next_s.dq_out = '0;
    end
    // no stall from buffer
    // Ready is granted one cycle ahead, so space must already be certain
    next_s.cmd_ready = (next_s.st == WR_IDLE) &&
      (lvl_next < `ECC_FIFO_LVL_W'(`ECC_FIFO_DEPTH));
  end

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign cmd_ready = s.cmd_ready;
  assign dq_out = s.dq_out;
  assign dq_oe = s.dq_oe;
  assign wr_limited = s.wr_limited;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  a_chk_stored_ok: assert property (
    (s.st == WR_BEATS && dq_in_valid && s.wleft == '0) |=>
      s.mem[$past(s.waddr)][`ECC_WORD_W-1:`ECC_DATA_W] ==
      ecc_gen(s.mem[$past(s.waddr)][`ECC_DATA_W-1:0]))
    else $error("stored check bits do not match stored data");

  a_rd_same_cycle: assert property (
    rd_go |-> (fifo_in_ready && fifo_in_data[`ECC_DATA_W-1:0] == ecc_fix(rd_raw)))
    else $error("read word not buffered in its fetch cycle");

  a_rd_no_rewrite: assert property (
    (rd_go && !flip_en) |=> $stable(s.mem))
    else $error("read changed the stored array");

  a_dq_beats_run: assert property (
    (dq_oe && dq_ready && s.rleft != '0) |=> (dq_oe && s.rbeat == $past(s.rbeat) + 1'b1))
    else $error("read burst broke before its last beat");

  a_dq_idle_zero: assert property (
    !dq_oe |-> dq_out == '0)
    else $error("data driven while output disabled");

  a_limited_flag: assert property (
    (s.st == WR_BEATS && dq_in_valid && s.wleft == '0) |=> (wr_limited == $past(s.limited)))
    else $error("limited flag wrong after write");

  a_mask_all_hold: assert property (
    (s.st == WR_BEATS && dq_in_valid && dq_mask == 2'h3 && s.wleft != '0) |=>
      $stable(s.asm_word))
    else $error("fully masked beat altered the word");

  a_wr_blocks_cmd: assert property (
    (s.st == WR_BEATS) |-> !cmd_ready)
    else $error("command accepted during write burst");

  a_no_drop_read: assert property (
    (cmd_ready && cmd_valid && !cmd_write) |-> fifo_in_ready)
    else $error("read accepted with no buffer space");

  a_one_bit_fix: assert property (
    (rd_go && (^rd_raw)) |->
      ($countones(fifo_in_data[`ECC_DATA_W-1:0] ^ rd_raw[`ECC_DATA_W-1:0]) <= 1))
    else $error("odd-parity read changed more than one data bit");

  a_multi_raw: assert property (
    (rd_go && !(^rd_raw)) |-> (fifo_in_data[`ECC_DATA_W-1:0] == rd_raw[`ECC_DATA_W-1:0]))
    else $error("even-parity read altered the data");

  a_first_beat_due: assert property (
    (rd_go && !dq_oe && fifo_level == '0) |-> ##2 dq_oe)
    else $error("first read beat late on an idle path");

  a_full_not_limited: assert property (
    (s.st == WR_IDLE && wr_go && cmd_beats == 2'h3) |=> !s.limited)
    else $error("full-length write marked limited");

endmodule // sdram_on_die_ecc_path

`default_nettype wire

// File: test/ctl_sink.sv
// Controller model that takes read beats, promptly or with stalls
`timescale 1ns/1ps
`default_nettype none
`include "ecc_path_consts.svh"

module ctl_sink
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [1:0] mode,
  input wire logic dq_oe,
  input wire logic [`ECC_BEAT_W-1:0] dq_out,
  output logic dq_ready
);
  logic [`ECC_DATA_W-1:0] words[$];
  logic [`ECC_DATA_W-1:0] acc;
  int nb;

  initial
  begin
    dq_ready = 1'b0;
    acc = '0;
    nb = 0;
  end

  always @(posedge clk_sys)
  begin
    if (resetn && dq_oe === 1'b1 && dq_ready)
    begin
      acc[nb*`ECC_BEAT_W +: `ECC_BEAT_W] = dq_out;
      nb = nb + 1;
      if (nb == 4)
      begin
        words.push_back(acc);
        nb = 0;
      end
    end
    // Mode 1 alternates, mode 2 holds off to back up the buffer
    dq_ready <= (mode == 2'd0) ? 1'b1 : (mode == 2'd1) ? ~dq_ready : 1'b0;
  end
endmodule // ctl_sink

`default_nettype wire

// File: test/tb_sdram_on_die_ecc_path.sv
// Self-checking bench of the error-correction path
`timescale 1ns/1ps
`default_nettype none
`include "ecc_path_consts.svh"
`define CHK(what, exp, got) \
  begin \
    num_checks++; \
    if ((got) !== (exp)) \
    begin \
      n_mismatch++; \
      $display("CHECK FAILED %s exp %h got %h", what, exp, got); \
    end \
  end

module tb_sdram_on_die_ecc_path;
  import ecc_path_pkg::*;
  logic clk_sys, resetn, cmd_valid, cmd_write, dq_in_valid, flip_en;
  logic cmd_ready, dq_oe, dq_ready, wr_limited;
  logic [`ECC_ADDR_W-1:0] cmd_addr, flip_addr;
  logic [`ECC_CNT_W-1:0] cmd_beats;
  logic [`ECC_BEAT_W-1:0] dq_in, dq_out;
  logic [`ECC_LANES-1:0] dq_mask;
  logic [`ECC_SYN_W-1:0] flip_bit;
  logic [1:0] mode;
  logic [`ECC_DATA_W-1:0] got;
  int n_mismatch, num_checks, n_lim;

  sdram_on_die_ecc_path dut_u (.clk_sys(clk_sys), .resetn(resetn), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_beats(cmd_beats), .cmd_ready(cmd_ready),
    .dq_in_valid(dq_in_valid), .dq_in(dq_in), .dq_mask(dq_mask), .dq_out(dq_out),
    .dq_oe(dq_oe), .dq_ready(dq_ready), .wr_limited(wr_limited), .flip_en(flip_en),
    .flip_addr(flip_addr), .flip_bit(flip_bit));
  ctl_sink ctl (.clk_sys(clk_sys), .resetn(resetn), .mode(mode), .dq_oe(dq_oe),
    .dq_out(dq_out), .dq_ready(dq_ready));

  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys)
  begin
    if (wr_limited === 1'b1)
      n_lim++;
  end

  function automatic logic [63:0] pat(input int i);
    pat = 64'hf0e1d2c3b4a59687 + i * 64'h0101010101010101;
  endfunction

  task automatic issue(input logic wr, input logic [3:0] a, input logic [1:0] nb);
    int t;
    begin
      t = 0;
      @(posedge clk_sys);
      cmd_valid <= 1'b1;
      cmd_write <= wr;
      cmd_addr <= a;
      cmd_beats <= nb;
      @(negedge clk_sys);
      while (cmd_ready !== 1'b1 && t < 50)
      begin
        t++;
        @(negedge clk_sys);
      end
      `CHK("command taken", 1'b1, cmd_ready)
      @(posedge clk_sys);
      cmd_valid <= 1'b0;
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [63:0] w, input logic [1:0] nb,
    input logic [1:0] m0);
    begin
      issue(1'b1, a, nb);
      for (int i = 0; i <= nb; i++)
      begin
        dq_in_valid <= 1'b1;
        dq_in <= w[i*16 +: 16];
        dq_mask <= (i == 0) ? m0 : 2'b00;
        @(posedge clk_sys);
      end
      dq_in_valid <= 1'b0;
      dq_mask <= 2'b00;
    end
  endtask

  task automatic rd(input logic [3:0] a, input logic [63:0] exp);
    int t;
    begin
      t = 0;
      issue(1'b0, a, 2'd3);
      // The buffer stage costs one edge before the first beat shows
      repeat (2) @(negedge clk_sys);
      `CHK("first beat", 1'b1, dq_oe)
      while (ctl.words.size() == 0 && t < 100)
      begin
        t++;
        @(negedge clk_sys);
      end
      got = (ctl.words.size() > 0) ? ctl.words.pop_front() : 'x;
      `CHK("read word", exp, got)
    end
  endtask

  task automatic flip(input logic [3:0] a, input logic [6:0] b);
    begin
      @(posedge clk_sys);
      flip_en <= 1'b1;
      flip_addr <= a;
      flip_bit <= b;
      @(posedge clk_sys);
      flip_en <= 1'b0;
    end
  endtask

  task automatic t_single();
    logic [6:0] bits [7];
    int l0;
    begin
      bits = '{7'h00, 7'h25, 7'h3f, 7'h40, 7'h45, 7'h46, 7'h47};
      for (int i = 0; i < 7; i++)
      begin
        l0 = n_lim;
        mode <= (i % 2 == 1) ? 2'd1 : 2'd0;
        wr(i[3:0], pat(i), 2'd3, 2'b00);
        flip(i[3:0], bits[i]);
        rd(i[3:0], pat(i));
        `CHK("full write flag", l0, n_lim)
      end
      mode <= 2'd0;
    end
  endtask

  task automatic t_double();
    begin
      wr(4'h9, pat(9), 2'd3, 2'b00);
      flip(4'h9, 7'h05);
      rd(4'h9, pat(9));
      flip(4'h9, 7'h28);
      rd(4'h9, pat(9) ^ 64'h0000010000000020);
      // scrub by rewriting the corrected word
      rd(4'h3, pat(3));
      wr(4'h3, pat(3), 2'd3, 2'b00);
      flip(4'h3, 7'h02);
      rd(4'h3, pat(3));
    end
  endtask

  task automatic t_short();
    logic [63:0] e;
    logic [63:0] p;
    int l0;
    begin
      wr(4'hc, pat(12), 2'd3, 2'b00);
      l0 = n_lim;
      wr(4'hc, pat(20), 2'd1, 2'b10);
      p = pat(20);
      e = pat(12);
      e[7:0] = p[7:0];
      e[31:16] = p[31:16];
      rd(4'hc, e);
      `CHK("short write flag", l0 + 1, n_lim)
      // Fully masked first beat keeps the old low 16 bits
      wr(4'hd, pat(13), 2'd3, 2'b00);
      wr(4'hd, pat(21), 2'd3, 2'b11);
      p = pat(21);
      e = pat(13);
      e[63:16] = p[63:16];
      rd(4'hd, e);
      `CHK("masked full write flag", l0 + 1, n_lim)
    end
  endtask

  task automatic t_fill();
    int taken, t;
    logic [63:0] e;
    logic [63:0] p;
    begin
      taken = 0;
      t = 0;
      p = pat(20);
      e = pat(12);
      e[7:0] = p[7:0];
      e[31:16] = p[31:16];
      mode <= 2'd2;
      @(posedge clk_sys);
      cmd_valid <= 1'b1;
      cmd_write <= 1'b0;
      cmd_addr <= 4'hc;
      cmd_beats <= 2'd3;
      repeat (20)
      begin
        @(negedge clk_sys);
        if (cmd_ready === 1'b1)
          taken++;
      end
      `CHK("buffer refuses", 1'b0, cmd_ready)
      `CHK("reads taken", `ECC_FIFO_DEPTH + 1, taken)
      @(posedge clk_sys);
      cmd_valid <= 1'b0;
      mode <= 2'd0;
      while (ctl.words.size() < taken && t < 200)
      begin
        t++;
        @(negedge clk_sys);
      end
      `CHK("words drained", taken, ctl.words.size())
      while (ctl.words.size() > 0)
      begin
        got = ctl.words.pop_front();
        `CHK("queued word", e, got)
      end
    end
  endtask

  task automatic conclude();
    begin
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask

  initial
  begin
    #100000;
    n_mismatch++;
    conclude();
  end

  initial
  begin
    {resetn, cmd_valid, cmd_write, dq_in_valid, flip_en} = '0;
    {cmd_addr, flip_addr, cmd_beats, dq_in, dq_mask, flip_bit, mode} = '0;
    repeat (6) @(posedge clk_sys);
    `CHK("reset outputs", 3'b000, {cmd_ready, dq_oe, wr_limited})
    resetn <= 1'b1;
    t_single();
    t_double();
    t_short();
    t_fill();
    conclude();
  end
endmodule // tb_sdram_on_die_ecc_path

`default_nettype wire
